// ==== core/flash_bus_cycle.sv ====
`timescale 1ns/10ps
module flash_bus_cycle
  import guard_ctrl_pkg::*;
#(
  parameter int AW = 23
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // Request side
  flash_bus_if.slave         cyc,
  // Flash pins
  output logic [AW-1:0]      flash_addr,
  output logic [15:0]        flash_dq_out,
  output logic               flash_dq_oe,
  input  wire logic [15:0]   flash_dq_in,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n
);

  logic [7:0]  cnt_reg;
  logic        busy_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  logic [15:0] rdata_reg;
  logic        done_reg;

  // ----------------------------------------
  // Two-flop capture of data pins
  // ----------------------------------------
  always_ff @(posedge clock) begin
    dq_s1_reg <= flash_dq_in;
    dq_s2_reg <= dq_s1_reg;
  end

  // ----------------------------------------
  // Strobe timing; one cycle per request
  // ----------------------------------------
  // Read data is sampled late so the sync pipe has settled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_reg     <= 1'b0;
      cnt_reg      <= 8'h00;
      done_reg     <= 1'b0;
      rdata_reg    <= 16'h0000;
      flash_addr   <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && cyc.req && !done_reg) begin
        busy_reg     <= 1'b1;
        cnt_reg      <= 8'(CYC_BUS + 3);
        flash_addr   <= cyc.addr;
        flash_dq_out <= cyc.wdata;
        flash_dq_oe  <= cyc.wr;
        flash_ce_n   <= 1'b0;
        flash_we_n   <= !cyc.wr;
        flash_oe_n   <= cyc.wr;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'(4)) begin
          flash_we_n <= 1'b1; // Rising WE latches data
        end
        if (cnt_reg == 8'h00) begin
          busy_reg    <= 1'b0;
          done_reg    <= 1'b1;
          rdata_reg   <= dq_s2_reg;
          flash_ce_n  <= 1'b1;
          flash_oe_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
        end
      end
    end
  end

  assign cyc.done  = done_reg;
  assign cyc.rdata = rdata_reg;

endmodule : flash_bus_cycle

// ==== core/flash_bus_if.sv ====
`timescale 1ns/10ps
interface flash_bus_if #(parameter int AW = 23);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic [15:0]   rdata;
  logic          done;
  modport master (output req, output wr, output addr, output wdata, input rdata, input done);
  modport slave  (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface : flash_bus_if

// ==== core/guard_ctrl_pkg.sv ====
package guard_ctrl_pkg;

  // ----------------------------------------
  // Register offsets on the Avalon-MM slave
  // ----------------------------------------
  localparam logic [3:0] OFF_CMD      = 4'h0;
  localparam logic [3:0] OFF_ADDR     = 4'h1;
  localparam logic [3:0] OFF_STATUS   = 4'h2;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
  localparam logic [3:0] OFF_RDATA    = 4'h5;
  localparam logic [3:0] OFF_CTRL     = 4'h6;

  // ----------------------------------------
  // Device command data codes
  // ----------------------------------------
  localparam logic [7:0] D_RESET      = 8'h_F0;
  localparam logic [7:0] D_SR_READ    = 8'h_70;
  localparam logic [7:0] D_SR_CLEAR   = 8'h_71;
  localparam logic [7:0] D_EXIT_ENTRY = 8'h_90;
  localparam logic [7:0] D_EXIT       = 8'h_00;
  localparam logic [7:0] D_PROG_ENTRY = 8'h_A0;
  localparam logic [7:0] D_SET        = 8'h_00;
  localparam logic [7:0] D_CLEAR      = 8'h_01;
  localparam logic [7:0] D_ERASE_ENT  = 8'h_80;
  localparam logic [7:0] D_ERASE_ALL  = 8'h_30;
  localparam logic [7:0] D_BUF_WRITE  = 8'h_25;
  localparam logic [11:0] A_STATUS    = 12'h_0555;

  // ----------------------------------------
  // Host operation codes written to OFF_CMD
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_GUARD_SET, OP_GUARD_ERASE, OP_FREEZE_SET, OP_VOL_SET,
    OP_VOL_CLEAR, OP_EXIT, OP_RESET, OP_SR_CLEAR, OP_BYP_PROG,
    OP_BYP_BUF, OP_BYP_ERASE, OP_READ
  } host_op_t;

  // ----------------------------------------
  // Bit positions and cycle counts
  // ----------------------------------------
  localparam int ST_BUSY    = 0;
  localparam int ST_HANG    = 1;
  localparam int ST_REFUSED = 2;
  localparam int SR_DONE    = 7;
  localparam int LR_ERASE_OK = 3;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_HANG   = 1;
  localparam int CLK_MHZ    = 25;
  localparam int T_CYCLE_NS = 80;
  localparam int CYC_BUS    = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

endpackage : guard_ctrl_pkg

// ==== core/sector_protect_command_fsm.sv ====
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Contract
// - Poll status bit 7; hang needs F0 reset
// - Freeze mode: A0,00 sets; 90,00 exits
// - Volatile mode: A0 then 00/01 at sector
// - Bypass: A0, 25, 80 select; 90,00 exits
module sector_protect_command_fsm
  import guard_ctrl_pkg::*;
#(
  parameter int AW       = 23,
  parameter int POLL_MAX = 100000
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  // Interrupt
  output logic               irq,
  // Flash pins
  output logic [AW-1:0]      flash_addr,
  output logic [15:0]        flash_dq_out,
  output logic               flash_dq_oe,
  input  wire logic [15:0]   flash_dq_in,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n
);

  typedef enum {
    S_IDLE, S_WRITE, S_WAIT_W, S_READ, S_WAIT_R, S_SR_CMD, S_SR_WAIT, S_POLL,
    S_POLL_WAIT, S_DONE
  } seq_state_t;

  flash_bus_if #(.AW(AW)) cyc ();

  flash_bus_cycle #(.AW(AW)) u_cycle (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .cyc          (cyc),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n)
  );

  seq_state_t    state_reg;
  host_op_t      op_reg;
  logic [AW-1:0] target_reg;
  logic [2:0]    step_reg;
  logic [2:0]    nsteps;
  logic          poll_op;
  logic          req_reg;
  logic          wr_reg;
  logic [AW-1:0] a_reg;
  logic [15:0]   d_reg;
  logic [15:0]   rdata_reg;
  logic [7:0]    ctrl_reg;
  logic [1:0]    irq_stat_reg;
  logic [1:0]    irq_mask_reg;
  logic          hang_reg;
  logic          refused_reg;
  logic [31:0]   poll_cnt_reg;
  logic          set_done;
  logic          set_hang;
  logic [AW-1:0] wa;
  logic [15:0]   wd;

  // ----------------------------------------
  // Command step table
  // ----------------------------------------
  // Each op but OP_READ is a short list of bus writes; guard set, guard erase and freeze set ops then poll
  function automatic logic [2:0] op_len(input host_op_t op);
    case (op)
      OP_GUARD_SET, OP_GUARD_ERASE, OP_FREEZE_SET, OP_VOL_SET, OP_VOL_CLEAR,
      OP_EXIT: op_len = 3'd2;
      OP_READ: op_len = 3'd0;
      default: op_len = 3'd1;
    endcase
  endfunction : op_len

  function automatic logic [15:0] widen(input logic [7:0] b);
    widen = {8'h00, b};
  endfunction : widen

  always_comb begin
    wa = '0;
    wd = 16'h0000;
    case (op_reg)
      OP_GUARD_SET, OP_FREEZE_SET: begin
        // Entry then set data at the sector
        wd = (step_reg == 3'd0) ? widen(D_PROG_ENTRY) : widen(D_SET);
        wa = (step_reg == 3'd0) ? '0 : target_reg;
      end
      OP_GUARD_ERASE: begin
        // Erase-all confirm goes to address zero
        wd = (step_reg == 3'd0) ? widen(D_ERASE_ENT) : widen(D_ERASE_ALL);
      end
      OP_VOL_SET, OP_VOL_CLEAR: begin
        // Set 00 or clear 01 at the sector
        wd = (step_reg == 3'd0) ? widen(D_PROG_ENTRY) :
             (op_reg == OP_VOL_SET) ? widen(D_SET) : widen(D_CLEAR);
        wa = (step_reg == 3'd0) ? '0 : target_reg;
      end
      OP_EXIT: begin
        // Exit pair for every mode
        wd = (step_reg == 3'd0) ? widen(D_EXIT_ENTRY) : widen(D_EXIT);
      end
      OP_RESET:     wd = widen(D_RESET);
      OP_SR_CLEAR: begin
        wd = widen(D_SR_CLEAR);
        wa = AW'(A_STATUS);
      end
      OP_BYP_PROG:  wd = widen(D_PROG_ENTRY);
      OP_BYP_BUF: begin
        wd = widen(D_BUF_WRITE); // Program address
        wa = target_reg;
      end
      OP_BYP_ERASE: wd = widen(D_ERASE_ENT);
      default: begin
        wd = 16'h0000;
        wa = '0;
      end
    endcase
  end

  assign nsteps  = op_len(op_reg);
  assign poll_op = (op_reg == OP_GUARD_SET) || (op_reg == OP_GUARD_ERASE) ||
                   (op_reg == OP_FREEZE_SET);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg    <= S_IDLE;
      step_reg     <= 3'd0;
      req_reg      <= 1'b0;
      wr_reg       <= 1'b0;
      a_reg        <= '0;
      d_reg        <= 16'h0000;
      rdata_reg    <= 16'h0000;
      hang_reg     <= 1'b0;
      refused_reg  <= 1'b0;
      poll_cnt_reg <= 32'h0000_0000;
      set_done     <= 1'b0;
      set_hang     <= 1'b0;
    end else begin
      set_done <= 1'b0;
      set_hang <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (avs_write && avs_address == OFF_CMD) begin
            step_reg <= 3'd0;
            // A stale hang flag would raise a second hang event on refusal
            hang_reg <= 1'b0;
            // Refuse erase-all unless the lock word allows it
            if (host_op_t'(avs_writedata[3:0]) == OP_GUARD_ERASE &&
                !ctrl_reg[LR_ERASE_OK]) begin
              refused_reg <= 1'b1;
              state_reg   <= S_DONE;
            end else begin
              refused_reg <= 1'b0;
              state_reg   <= (host_op_t'(avs_writedata[3:0]) == OP_READ) ? S_READ : S_WRITE;
            end
          end
        end
        S_WRITE: begin
          req_reg   <= 1'b1;
          wr_reg    <= 1'b1;
          a_reg     <= wa;
          d_reg     <= wd;
          state_reg <= S_WAIT_W;
        end
        S_WAIT_W: begin
          if (cyc.done) begin
            req_reg <= 1'b0;
            if (step_reg + 3'd1 < nsteps) begin
              step_reg  <= step_reg + 3'd1;
              state_reg <= S_WRITE;
            end else begin
              poll_cnt_reg <= 32'h0000_0000;
              state_reg    <= poll_op ? S_SR_CMD : S_DONE;
            end
          end
        end
        S_READ: begin
          req_reg   <= 1'b1;
          wr_reg    <= 1'b0;
          a_reg     <= target_reg;
          state_reg <= S_WAIT_R;
        end
        S_WAIT_R: begin
          if (cyc.done) begin
            req_reg   <= 1'b0;
            rdata_reg <= cyc.rdata;
            state_reg <= S_DONE;
          end
        end
        S_SR_CMD: begin
          // Status read entry 70 at 555; reads show the status word after it
          req_reg   <= 1'b1;
          wr_reg    <= 1'b1;
          a_reg     <= AW'(A_STATUS);
          d_reg     <= widen(D_SR_READ);
          state_reg <= S_SR_WAIT;
        end
        S_SR_WAIT: begin
          if (cyc.done) begin
            req_reg   <= 1'b0;
            state_reg <= S_POLL;
          end
        end
        S_POLL: begin
          // Poll status read at the status address
          req_reg   <= 1'b1;
          wr_reg    <= 1'b0;
          a_reg     <= AW'(A_STATUS);
          state_reg <= S_POLL_WAIT;
        end
        S_POLL_WAIT: begin
          if (cyc.done) begin
            req_reg      <= 1'b0;
            rdata_reg    <= cyc.rdata;
            poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
            if (cyc.rdata[SR_DONE]) begin
              // Bit 7 high while in guard op means hang: send F0
              hang_reg  <= 1'b1;
              state_reg <= S_WRITE;
            end else if (poll_cnt_reg >= 32'(POLL_MAX)) begin
              // Poll limit POLL_MAX reached without bit 7 set
              state_reg <= S_DONE;
            end else begin
              state_reg <= S_POLL;
            end
          end
        end
        S_DONE: begin
          set_done  <= !refused_reg;
          set_hang  <= hang_reg;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Latched operation and target
  // ----------------------------------------
  // On a hang the op turns into a reset so the sequencer reuses S_WRITE
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op_reg     <= OP_NONE;
      target_reg <= '0;
    end else begin
      if (state_reg == S_IDLE && avs_write && avs_address == OFF_CMD) begin
        op_reg <= host_op_t'(avs_writedata[3:0]);
      end else if (state_reg == S_POLL_WAIT && cyc.done && cyc.rdata[SR_DONE]) begin
        op_reg <= OP_RESET;
      end
      // Kept apart so an address write is never lost to a hang turn
      if (avs_write && avs_address == OFF_ADDR) begin
        target_reg <= avs_writedata[AW-1:0];
      end
    end
  end

  assign cyc.req   = req_reg;
  assign cyc.wr    = wr_reg;
  assign cyc.addr  = a_reg;
  assign cyc.wdata = d_reg;

  // ----------------------------------------
  // Control, interrupt status and mask
  // ----------------------------------------
  // Set wins over write-one-to-clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg     <= 8'h00;
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= MASK_RESET;
    end else begin
      if (avs_write && avs_address == OFF_CTRL) ctrl_reg <= avs_writedata[7:0];
      if (avs_write && avs_address == OFF_IRQ_MASK) irq_mask_reg <= avs_writedata[1:0];
      irq_stat_reg <= (irq_stat_reg &
                       ~((avs_write && avs_address == OFF_IRQ_STAT) ?
                         avs_writedata[1:0] : 2'b00)) |
                      {set_hang, set_done};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // Command writes stall while a sequence runs
  assign avs_waitrequest = avs_write && avs_address == OFF_CMD && state_reg != S_IDLE;

  always_comb begin
    case (avs_address)
      OFF_ADDR:     avs_readdata = 32'(target_reg);
      OFF_STATUS:   avs_readdata = {29'h0, refused_reg, hang_reg, state_reg != S_IDLE};
      OFF_IRQ_STAT: avs_readdata = {30'h0, irq_stat_reg};
      OFF_IRQ_MASK: avs_readdata = {30'h0, irq_mask_reg};
      OFF_RDATA:    avs_readdata = {16'h0000, rdata_reg};
      OFF_CTRL:     avs_readdata = {24'h00_0000, ctrl_reg};
      default:      avs_readdata = 32'h0000_0000;
    endcase
  end

endmodule : sector_protect_command_fsm

// ==== dv/flash_guard_model.sv ====
`timescale 1ns/10ps
module flash_guard_model #(
  parameter int AW = 23
) (
  // Flash pins
  input  wire logic [AW-1:0] flash_addr,
  input  wire logic [15:0]   flash_dq_out,
  output logic [15:0]        flash_dq_in,
  input  wire logic          flash_ce_n,
  input  wire logic          flash_we_n,
  input  wire logic          flash_oe_n,
  // Test knobs
  input  wire logic          lock_bit3,
  input  wire logic          hang_en
);
  // ----------------------------------------
  // Command state, 0 read 1 guard 2 freeze 3 volatile 4 bypass
  // ----------------------------------------
  int           mode = 0;
  int           pend = 0;
  logic [127:0] guard_bits = '0;
  logic [127:0] vol_bits = '0;
  logic         freeze = 1'b0;
  logic         hang = 1'b0;
  logic         sr_sel = 1'b0;
  logic [7:0]   byp_sel = 8'h_00;
  logic [7:0]   last_d = 8'h_00;
  logic [AW-1:0] last_a = '0;
  logic [7:0]   d;
  logic [6:0]   sec;
  logic [15:0]  rd_q;
  // Released bus shows the inverse, no pull on the data lines
  assign rd_q = sr_sel ? {8'h_00, hang, 7'h_00} : (16'h_5A00 ^ flash_addr[15:0]);
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_q : ~rd_q;
  // Command decode on the closing edge of each write
  always @(posedge flash_we_n) begin
    if (!flash_ce_n) begin
      d = flash_dq_out[7:0];
      sec = flash_addr[AW-1 -: 7];
      last_d = d;
      last_a = flash_addr;
      sr_sel = (d == 8'h_70);
      if (d == 8'h_F0) begin
        pend = 0;
        hang = 1'b0;
        if (mode == 2) mode = 0;
      end else if (pend == 1) begin
        pend = 0;
        if (mode == 1 && d == 8'h_00 && !hang_en) guard_bits[sec] = 1'b1;
        if (mode == 1 && d == 8'h_00 && hang_en) hang = 1'b1;
        if (mode == 2 && d == 8'h_00) freeze = 1'b1;
        if (mode == 3 && d <= 8'h_01) vol_bits[sec] = !d[0];
      end else if (pend == 2) begin
        pend = 0;
        if (d == 8'h_30 && flash_addr == '0 && !hang_en) guard_bits = '0;
      end else if (pend == 3) begin
        pend = 0;
        if (d == 8'h_00) mode = 0;
      end else if (d == 8'h_90) pend = 3;
      else if (mode == 4) byp_sel = d;
      else if (d == 8'h_A0 && mode != 0) pend = 1;
      else if (d == 8'h_80 && mode == 1 && lock_bit3) pend = 2;
    end
  end
endmodule : flash_guard_model

// ==== dv/guard_cmd_checker.sv ====
`timescale 1ns/10ps
module guard_cmd_checker
  import guard_ctrl_pkg::*;
#(
  parameter int AW = 23
) (
  // Clock and reset
  input wire logic          clock,
  input wire logic          sys_rst,
  // Avalon-MM slave
  input wire logic [3:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_writedata,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  // Interrupt
  input wire logic          irq,
  // Flash pins
  input wire logic [AW-1:0] flash_addr,
  input wire logic [15:0]   flash_dq_out,
  input wire logic          flash_dq_oe,
  input wire logic [15:0]   flash_dq_in,
  input wire logic          flash_ce_n,
  input wire logic          flash_we_n,
  input wire logic          flash_oe_n
);
  // ----------------------------------------
  // Bus cycle properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Write strobe must end, a hung strobe would corrupt the command order
  sequence s_we_end;
    ##[1:40] $rose(flash_we_n);
  endsequence
  property p_we_pulse;
    $fell(flash_we_n) |-> (!flash_ce_n) throughout s_we_end;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe not closed in time");
  property p_we_drive;
    !flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n;
  endproperty
  a_we_drive: assert property (p_we_drive)
    else $error("write cycle without data drive");
  property p_oe_float;
    !flash_oe_n |-> !flash_dq_oe && flash_we_n;
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("bus contention on read");
  property p_hold;
    !flash_we_n && $past(!flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved in write");
  property p_rst_quiet;
    $fell(sys_rst) |-> flash_ce_n && flash_we_n && !irq;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  property p_wait_cmd;
    avs_waitrequest |-> avs_write && avs_address == OFF_CMD;
  endproperty
  a_wait_cmd: assert property (p_wait_cmd)
    else $error("stall on non-command access");
  property p_read_now;
    avs_read |-> !avs_waitrequest;
  endproperty
  a_read_now: assert property (p_read_now)
    else $error("read stalled");
  property p_mask_off;
    avs_write && !avs_waitrequest && avs_address == OFF_IRQ_MASK
      && avs_writedata[1:0] == 2'h0 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with all masked");
endmodule : guard_cmd_checker

bind sector_protect_command_fsm guard_cmd_checker #(.AW(AW)) chk_u (
  .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
);

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import guard_ctrl_pkg::*;
  // ----------------------------------------
  // Stimulus and checking
  // ----------------------------------------
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h_0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [22:0] flash_addr;
  logic [15:0] flash_dq_out;
  logic        flash_dq_oe;
  logic [15:0] flash_dq_in;
  logic        flash_ce_n;
  logic        flash_we_n;
  logic        flash_oe_n;
  logic        lock_bit3 = 1'b0;
  logic        hang_en = 1'b0;
  logic [31:0] rd;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #20 clock = ~clock;

  // Poll limit shortened so a guard operation finishes in a few reads
  sector_protect_command_fsm #(.AW(23), .POLL_MAX(4)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  flash_guard_model #(.AW(23)) model_u (
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .lock_bit3(lock_bit3), .hang_en(hang_en));

  task end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Request held until a rising edge with waitrequest low, sampled at that edge
  task av_xfer(input logic is_rd, input logic [3:0] a, input logic [31:0] d);
    logic w;
    int   n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= is_rd;
    avs_write     <= !is_rd;
    do begin
      @(posedge clock);
      w  = avs_waitrequest;
      rd = avs_readdata;
      n++;
    end while (w !== 1'b0 && n < 2000);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0) begin
      n_fail++;
      end_sim();
    end
  endtask : av_xfer

  task av_wr(input logic [3:0] a, input logic [31:0] d);
    av_xfer(1'b0, a, d);
  endtask : av_wr

  task av_rd(input logic [3:0] a);
    av_xfer(1'b1, a, 32'h_0000_0000);
  endtask : av_rd

  task wait_idle;
    int n;
    n = 0;
    do begin
      av_rd(OFF_STATUS);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 500);
    if (rd[ST_BUSY] !== 1'b0) begin
      n_fail++;
      end_sim();
    end
  endtask : wait_idle

  task run_op(input host_op_t op, input logic [22:0] a);
    av_wr(OFF_ADDR, 32'(a));
    av_wr(OFF_CMD, 32'(op));
    wait_idle();
  endtask : run_op

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    av_rd(OFF_IRQ_STAT);
    check(rd | 32'(irq), 32'h_0000_0000);
    run_op(OP_READ, 23'h00_0123);
    av_rd(OFF_RDATA);
    check(rd, 32'h_0000_5B23);
    $display("test reset and read done");
    model_u.mode = 1;
    av_wr(OFF_IRQ_MASK, 32'h_0000_0003);
    run_op(OP_GUARD_SET, 23'h05_0000);
    check({31'h0, model_u.guard_bits[5]}, 32'h_0000_0001);
    check(32'(model_u.mode), 32'h_0000_0001);
    av_rd(OFF_IRQ_STAT);
    check({rd[1:0], 30'h0} | 32'(irq), 32'h_4000_0001);
    av_wr(OFF_IRQ_STAT, 32'h_0000_0001);
    av_rd(OFF_IRQ_STAT);
    check(rd | 32'(irq), 32'h_0000_0000);
    $display("test guard set done");
    hang_en = 1'b1;
    run_op(OP_GUARD_SET, 23'h09_0000);
    hang_en = 1'b0;
    av_rd(OFF_STATUS);
    check(32'(rd[ST_HANG]), 32'h_0000_0001);
    check({30'h0, model_u.guard_bits[9], model_u.guard_bits[5]}, 32'h_0000_0001);
    check({model_u.hang, 31'(model_u.mode)}, 32'h_0000_0001);
    av_rd(OFF_IRQ_STAT);
    check(32'(rd[IRQ_HANG]) | 32'(irq), 32'h_0000_0001);
    av_wr(OFF_IRQ_STAT, 32'h_0000_0003);
    $display("test hang done");
    av_wr(OFF_CTRL, 32'h_0000_0000);
    run_op(OP_GUARD_ERASE, 23'h00_0000);
    av_rd(OFF_STATUS);
    check(32'(rd[ST_REFUSED]), 32'h_0000_0001);
    av_rd(OFF_IRQ_STAT);
    check(32'(rd[IRQ_DONE]) | 32'(model_u.guard_bits[5] == 1'b0), 32'h_0000_0000);
    lock_bit3 = 1'b1;
    av_wr(OFF_CTRL, 32'h_0000_0008);
    run_op(OP_GUARD_ERASE, 23'h00_0000);
    check(32'(model_u.guard_bits == '0) | 32'(model_u.mode << 1), 32'h_0000_0003);
    run_op(OP_SR_CLEAR, 23'h00_0000);
    check({model_u.last_d, 12'h0, model_u.last_a[11:0]}, 32'h_7100_0555);
    av_wr(OFF_IRQ_MASK, 32'h_0000_0000);
    $display("test erase done");
    model_u.mode = 2;
    run_op(OP_FREEZE_SET, 23'h00_0000);
    check({31'(model_u.mode), model_u.freeze}, 32'h_0000_0005);
    run_op(OP_EXIT, 23'h00_0000);
    check(32'(model_u.mode), 32'h_0000_0000);
    model_u.mode = 2;
    run_op(OP_RESET, 23'h00_0000);
    check(32'(model_u.mode), 32'h_0000_0000);
    $display("test freeze done");
    model_u.mode = 3;
    run_op(OP_VOL_SET, 23'h03_0000);
    check(32'(model_u.vol_bits[3]), 32'h_0000_0001);
    run_op(OP_VOL_CLEAR, 23'h03_0000);
    check(32'(model_u.vol_bits[3]) | 32'(model_u.mode << 1), 32'h_0000_0006);
    run_op(OP_EXIT, 23'h00_0000);
    check(32'(model_u.mode), 32'h_0000_0000);
    $display("test volatile done");
    model_u.mode = 4;
    run_op(OP_BYP_PROG, 23'h00_0000);
    check(32'(model_u.byp_sel), 32'h_0000_00A0);
    run_op(OP_BYP_BUF, 23'h01_2340);
    check({model_u.byp_sel, 1'b0, model_u.last_a}, 32'h_2501_2340);
    av_wr(OFF_CMD, 32'(OP_BYP_PROG));
    av_wr(OFF_CMD, 32'(OP_BYP_ERASE));
    wait_idle();
    check(32'(model_u.byp_sel), 32'h_0000_0080);
    run_op(OP_EXIT, 23'h00_0000);
    check(32'(model_u.mode), 32'h_0000_0000);
    $display("test bypass done");
    end_sim();
  end
endmodule : testbench
